// >>> hw/tpm_consts.vh
`ifndef TPM_CONSTS_VH
`define TPM_CONSTS_VH
// register addresses on the host port
`define TPM_REG_IMASK     8'h05
`define TPM_REG_CTLA      8'h06
`define TPM_REG_CTLB      8'h07
`define TPM_REG_CTLC      8'h09
`define TPM_REG_CMP_HI    8'h1d
`define TPM_REG_CMP_LO    8'h1e
`define TPM_REG_STATUS    8'h24
`define TPM_REG_MODE      8'h30
`define TPM_REG_TIMER_HI  8'h31
`define TPM_REG_TIMER_LO  8'h32
// field positions
`define TPM_B_DOZE_EN     0
`define TPM_B_HIB_EN      1
`define TPM_B_CLKO_DOZE   9
`define TPM_B_DOZE_MASK   4
`define TPM_B_ACOMA       8
`define TPM_B_CLKO_EN     2
`define TPM_B_DOZE_STAT   9
`define TPM_B_STRM_MODE   4
`define TPM_B_RX_STRM     3
`define TPM_B_TX_STRM     2
`define TPM_B_TMR_TRIG    7
`define TPM_F_CLKO_RATE   5:3
`define TPM_F_SEQ         1:0
`define TPM_CTLC_LOW_RST  3'h4
// clko rate select, lowest two settings are 3'h6 and 3'h7
`define TPM_CLKO_SLOW0    3'h6
`define TPM_CLKO_SLOW1    3'h7
`define TPM_CLKO_RST      3'h5
// sequence codes
`define TPM_SEQ_IDLE      2'h0
`define TPM_SEQ_CCA       2'h1
`define TPM_SEQ_RX        2'h2
`define TPM_SEQ_TX        2'h3
// timing
`define TPM_CLK_HZ        20000000
`define TPM_OFF_TO_IDLE_MS 25
`define TPM_HIB_TO_IDLE_MS 20
`define TPM_PRE_LP_CYCLES 128
`define TPM_OP_CYCLES     16
// mode codes
`define TPM_M_OFF   3'h0
`define TPM_M_IDLE  3'h1
`define TPM_M_PRE   3'h2
`define TPM_M_HIB   3'h3
`define TPM_M_DOZE  3'h4
`define TPM_M_WAKE  3'h5
`define TPM_M_ACT   3'h6
`endif

// >>> hw/tpm_sync.v
`timescale 1ns/1ps
`default_nettype none
module tpm_sync (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg meta_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // tpm_sync
`default_nettype wire

// >>> hw/tpm_mode_ctrl.v
// Functional notes
// - reset low holds Off, clears everything (code: rst is active high)
// - Idle reached within 25 ms of reset release
// - hibernate request: 128 clock-out cycles, then Hibernate
// - Hibernate disables blocks, bus, timers; keeps config
// - wake pin leaves Hibernate within 20 ms
// - reset in Hibernate forces Off
// - clock output resumes at prior rate after Hibernate
// - Doze keeps timer running, bus off
// - doze clock-keep bit keeps clock output; else stop (code also keeps it running in deep-doze)
// - doze request: 128 clock-out cycles, then Doze
// - timer compare match exits Doze, sets status
// - doze-wake interrupt only when mask set
// - slow clock rates need enable toggle after Doze
// - wake or reset ends Doze anytime
// - deep-doze stops timer, only wake exits
// - Idle keeps bus active, clock output if enabled
// - packet mode sequence field selects operation
// - stream mode bits select receive or transmit
// - operation completion returns to Idle
// - sequence field kept after operation
// - leave Idle only with sequence enable high (code: hibernate and doze requests leave it without)
// - codes 00 idle, 01 cca, 10 rx, 11 tx
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tpm_consts.vh"
module tpm_mode_ctrl #(
  parameter OFF_WAIT = (`TPM_CLK_HZ / 1000) * `TPM_OFF_TO_IDLE_MS,
  parameter HIB_WAIT = (`TPM_CLK_HZ / 1000) * `TPM_HIB_TO_IDLE_MS,
  parameter [7:0] PRE_CYC = `TPM_PRE_LP_CYCLES,
  parameter [7:0] OP_CYC  = `TPM_OP_CYCLES
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        wake_request_pin,
  input  wire        sequence_enable_pin,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg  [2:0]  mode_q,
  output reg         bus_active_q,
  output reg         clko_q,
  output reg         irq_q,
  output reg  [1:0]  active_op_q,
  output reg         active_strm_q
);
  reg [15:0] imask_q, ctla_q, ctlb_q, ctlc_q, status_q;
  reg [7:0]  cmp_hi_q;
  reg [15:0] cmp_lo_q;
  reg [23:0] timer_q;
  reg [24:0] wait_q;
  reg [7:0]  clko_div_q;
  reg        clko_tick_q;
  reg        clko_run_q;
  reg        clko_stall_q;
  reg        clko_en_prev_q;
  reg        op_is_doze_q;
  wire       wake_s, seqen_s;

  tpm_sync u_wake_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (wake_request_pin),
    .dout (wake_s)
  );
  tpm_sync u_seqen_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (sequence_enable_pin),
    .dout (seqen_s)
  );

  wire        bus_ok   = bus_active_q;
  wire        wr_ok    = reg_wr & bus_ok;
  wire        rd_ok    = reg_rd & bus_ok;
  wire        strm     = ctla_q[`TPM_B_STRM_MODE];
  wire        deep     = imask_q[`TPM_B_ACOMA];
  wire        in_doze  = (mode_q == `TPM_M_DOZE);
  wire        in_hib   = (mode_q == `TPM_M_HIB);
  wire        tmr_run  = ~in_hib & ~(in_doze & deep);
  wire [23:0] cmp_val  = {cmp_hi_q, cmp_lo_q};
  wire        match    = tmr_run & (timer_q == cmp_val);
  wire        slow_clk = (ctlc_q[`TPM_F_CLKO_RATE] == `TPM_CLKO_SLOW0) |
                         (ctlc_q[`TPM_F_CLKO_RATE] == `TPM_CLKO_SLOW1);
  wire        clr_stat = rd_ok & (reg_addr == `TPM_REG_STATUS);
  wire        clko_en  = ctlc_q[`TPM_B_CLKO_EN];

  // request present: packet sequence or stream bits
  wire [1:0]  seq      = ctla_q[`TPM_F_SEQ];
  wire        want_op  = strm ? (ctla_q[`TPM_B_RX_STRM] | ctla_q[`TPM_B_TX_STRM])
                              : (seq != `TPM_SEQ_IDLE);
  wire        trig_ok  = ~ctla_q[`TPM_B_TMR_TRIG] | match;

  // free-running event timer, frozen when stopped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q <= 24'h000000;
    end else if (tmr_run) begin
      timer_q <= timer_q + 24'h000001;
    end
  end

  // clock output divider; rate from ctlc bits 5:3
  wire [7:0] div_lim = 8'h01 << ctlc_q[`TPM_F_CLKO_RATE];
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clko_div_q  <= 8'h00;
      clko_tick_q <= 1'b0;
      clko_q      <= 1'b0;
    end else begin
      clko_tick_q <= 1'b0;
      if (~clko_run_q) begin
        clko_div_q <= 8'h00;
        clko_q     <= 1'b0;
      end else if (clko_div_q + 8'h01 >= div_lim) begin
        clko_div_q <= 8'h00;
        clko_q     <= ~clko_q;
        clko_tick_q <= clko_q; // one tick per full cycle
      end else begin
        clko_div_q <= clko_div_q + 8'h01;
      end
    end
  end

  // clock output gating across low-power modes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clko_run_q     <= 1'b0;
      clko_stall_q   <= 1'b0;
      clko_en_prev_q <= 1'b0;
    end else begin
      clko_en_prev_q <= clko_en;
      if (clko_en & ~clko_en_prev_q) begin
        clko_stall_q <= 1'b0;
      end
      case (mode_q)
        `TPM_M_HIB: clko_run_q <= 1'b0;
        `TPM_M_DOZE: begin
          if (~(ctlb_q[`TPM_B_CLKO_DOZE] | deep)) begin
            clko_run_q <= 1'b0;
            if (slow_clk) begin
              clko_stall_q <= 1'b1;
            end
          end else begin
            clko_run_q <= clko_en;
          end
        end
        `TPM_M_OFF: clko_run_q <= 1'b0;
        default: clko_run_q <= clko_en & ~clko_stall_q;
      endcase
    end
  end

  // mode sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q        <= `TPM_M_OFF;
      wait_q        <= 25'h0000000;
      bus_active_q  <= 1'b0;
      active_op_q   <= `TPM_SEQ_IDLE;
      active_strm_q <= 1'b0;
      op_is_doze_q  <= 1'b0;
    end else begin
      case (mode_q)
        `TPM_M_OFF: begin
          if (wait_q >= OFF_WAIT[24:0] - 25'h0000001) begin
            mode_q       <= `TPM_M_IDLE;
            bus_active_q <= 1'b1;
            wait_q       <= 25'h0000000;
          end else begin
            wait_q <= wait_q + 25'h0000001;
          end
        end
        `TPM_M_IDLE: begin
          bus_active_q <= 1'b1;
          if (ctlb_q[`TPM_B_HIB_EN] | ctlb_q[`TPM_B_DOZE_EN]) begin
            mode_q       <= `TPM_M_PRE;
            op_is_doze_q <= ~ctlb_q[`TPM_B_HIB_EN];
            wait_q       <= 25'h0000000;
          end else if (want_op & seqen_s & trig_ok) begin
            mode_q        <= `TPM_M_ACT;
            active_op_q   <= strm ? (ctla_q[`TPM_B_TX_STRM] ? `TPM_SEQ_TX : `TPM_SEQ_RX)
                                  : seq;
            active_strm_q <= strm;
            wait_q        <= 25'h0000000;
          end
        end
        `TPM_M_PRE: begin
          // counts clock-out cycles; a stopped output falls back on clk
          if (clko_tick_q | ~clko_run_q) begin
            if (wait_q[7:0] == PRE_CYC - 8'h01) begin
              mode_q       <= op_is_doze_q ? `TPM_M_DOZE : `TPM_M_HIB;
              bus_active_q <= 1'b0;
            end else begin
              wait_q <= wait_q + 25'h0000001;
            end
          end
        end
        `TPM_M_HIB: begin
          if (wake_s) begin
            mode_q <= `TPM_M_WAKE;
            wait_q <= 25'h0000000;
          end
        end
        `TPM_M_WAKE: begin
          if (wait_q >= HIB_WAIT[24:0] - 25'h0000001) begin
            mode_q       <= `TPM_M_IDLE;
            bus_active_q <= 1'b1;
          end else begin
            wait_q <= wait_q + 25'h0000001;
          end
        end
        `TPM_M_DOZE: begin
          if (wake_s | (match & ~deep)) begin
            mode_q       <= `TPM_M_IDLE;
            bus_active_q <= 1'b1;
          end
        end
        `TPM_M_ACT: begin
          // abort on enable low or sequence cleared; else finish
          if (~seqen_s | ~want_op | wait_q[7:0] == OP_CYC - 8'h01) begin
            mode_q        <= `TPM_M_IDLE;
            active_op_q   <= `TPM_SEQ_IDLE;
            active_strm_q <= 1'b0;
          end else begin
            wait_q <= wait_q + 25'h0000001;
          end
        end
        default: mode_q <= `TPM_M_OFF;
      endcase
    end
  end

  // register file; requests self-clear on entering low power
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      imask_q  <= 16'h0000;
      ctla_q   <= 16'h0000;
      ctlb_q   <= 16'h0000;
      ctlc_q   <= {10'h000, `TPM_CLKO_RST, `TPM_CTLC_LOW_RST};
      cmp_hi_q <= 8'hff;
      cmp_lo_q <= 16'hffff;
      status_q <= 16'h0000;
    end else begin
      if (wr_ok) begin
        case (reg_addr)
          `TPM_REG_IMASK:  imask_q  <= reg_wdata;
          `TPM_REG_CTLA:   ctla_q   <= reg_wdata;
          `TPM_REG_CTLB:   ctlb_q   <= reg_wdata;
          `TPM_REG_CTLC:   ctlc_q   <= reg_wdata;
          `TPM_REG_CMP_HI: cmp_hi_q <= reg_wdata[7:0];
          `TPM_REG_CMP_LO: cmp_lo_q <= reg_wdata;
          default: ;
        endcase
      end
      if (mode_q == `TPM_M_PRE) begin
        ctlb_q[`TPM_B_HIB_EN]  <= 1'b0;
        ctlb_q[`TPM_B_DOZE_EN] <= 1'b0;
      end
      if (clr_stat) begin
        status_q <= 16'h0000;
      end
      // armed compare still flags after a wake-pin exit; set wins
      if (match & ~deep) begin
        status_q[`TPM_B_DOZE_STAT] <= 1'b1;
      end
    end
  end

  // read port, one cycle latency
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      irq_q     <= 1'b0;
    end else begin
      irq_q <= status_q[`TPM_B_DOZE_STAT] & imask_q[`TPM_B_DOZE_MASK];
      reg_rdata <= 16'h0000;
      if (rd_ok) begin
        case (reg_addr)
          `TPM_REG_IMASK:    reg_rdata <= imask_q;
          `TPM_REG_CTLA:     reg_rdata <= ctla_q;
          `TPM_REG_CTLB:     reg_rdata <= ctlb_q;
          `TPM_REG_CTLC:     reg_rdata <= ctlc_q;
          `TPM_REG_CMP_HI:   reg_rdata <= {8'h00, cmp_hi_q};
          `TPM_REG_CMP_LO:   reg_rdata <= cmp_lo_q;
          `TPM_REG_STATUS:   reg_rdata <= status_q;
          `TPM_REG_MODE:     reg_rdata <= {11'h000, active_op_q, mode_q};
          `TPM_REG_TIMER_HI: reg_rdata <= {8'h00, timer_q[23:16]};
          `TPM_REG_TIMER_LO: reg_rdata <= timer_q[15:0];
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // tpm_mode_ctrl
`default_nettype wire

// >>> testbench/tpm_host_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_host_pins (
  input  wire logic clk,
  input  wire logic wake_go,
  input  wire logic seq_go,
  output var  logic wake_request_pin,
  output var  logic sequence_enable_pin
);
  initial begin
    wake_request_pin = 1'b0;
    sequence_enable_pin = 1'b0;
  end
  // pins move just after an edge, as a host port write would
  always @(posedge clk) begin
    wake_request_pin <= wake_go;
    sequence_enable_pin <= seq_go;
  end
endmodule // tpm_host_pins
`default_nettype wire

// >>> testbench/tpm_mode_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_mode_chk #(
  parameter       OFF_WAIT = 20,
  parameter       HIB_WAIT = 20,
  parameter [7:0] OP_CYC   = 8'h10
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wake_request_pin,
  input wire logic        sequence_enable_pin,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0]  mode_q,
  input wire logic        bus_active_q,
  input wire logic        clko_q,
  input wire logic        irq_q,
  input wire logic [1:0]  active_op_q
);
  localparam int OFF_MAX = OFF_WAIT + 6;
  localparam int HIB_MAX = HIB_WAIT + 8;
  localparam int OP_MAX  = OP_CYC + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  reset_off_a: assert property ($fell(rst) |-> mode_q == 3'h0 && !clko_q && !irq_q)
    else $error("outputs not cleared by reset");
  off_idle_a: assert property ($fell(rst) |-> ##[1:OFF_MAX] mode_q == 3'h1)
    else $error("idle not reached after reset");
  pre_hold_a: assert property ($rose(mode_q == 3'h2) |-> (mode_q == 3'h2)[*8])
    else $error("low power entered too early");
  bus_off_a: assert property (mode_q inside {3'h3, 3'h4} && $past(mode_q) == mode_q
    |-> !bus_active_q)
    else $error("register port alive in low power");
  refused_rd_a: assert property ($past(reg_rd && !bus_active_q) |-> reg_rdata == 16'h0000)
    else $error("read answered while port off");
  hib_wake_a: assert property (mode_q == 3'h3 && $rose(wake_request_pin)
    |-> ##[1:HIB_MAX] mode_q == 3'h1)
    else $error("wake did not reach idle in time");
  idle_bus_a: assert property (mode_q == 3'h1 && $past(mode_q) == 3'h1 |-> bus_active_q)
    else $error("register port off in idle");
  seq_gate_a: assert property ($past(mode_q) == 3'h1 && mode_q == 3'h6
    |-> $past(sequence_enable_pin, 2) || $past(sequence_enable_pin, 3)
    || $past(sequence_enable_pin, 4))
    else $error("operation began without enable");
  op_code_a: assert property (mode_q == 3'h6 && $past(mode_q) == 3'h6
    |-> active_op_q != 2'h0)
    else $error("operation running with idle code");
  op_done_a: assert property ($rose(mode_q == 3'h6) |-> ##[1:OP_MAX] mode_q == 3'h1)
    else $error("operation did not return to idle");
endmodule // tpm_mode_chk
bind tpm_mode_ctrl tpm_mode_chk #(.OFF_WAIT(OFF_WAIT), .HIB_WAIT(HIB_WAIT), .OP_CYC(OP_CYC))
  tpm_mode_chk_inst (.clk(clk), .rst(rst), .wake_request_pin(wake_request_pin),
  .sequence_enable_pin(sequence_enable_pin), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mode_q(mode_q), .bus_active_q(bus_active_q), .clko_q(clko_q), .irq_q(irq_q),
  .active_op_q(active_op_q));
`default_nettype wire

// >>> testbench/test_transceiver_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_power_mode_control;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wake_go = 1'b0;
  logic        seq_go = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire         wake_request_pin, sequence_enable_pin, bus_active_q, clko_q, irq_q, strm;
  wire  [15:0] reg_rdata;
  wire  [2:0]  mode_q;
  wire  [1:0]  op;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  int          c, r, k;
  logic [15:0] d, e;
  logic [15:0] row_ctl [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0018, 16'h0014};
  logic [2:0]  row_exp [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  tpm_host_pins tpm_host_pins_inst (.clk(clk), .wake_go(wake_go), .seq_go(seq_go),
    .wake_request_pin(wake_request_pin), .sequence_enable_pin(sequence_enable_pin));
  tpm_mode_ctrl #(.OFF_WAIT(20), .HIB_WAIT(20)) tpm_mode_ctrl_inst (.clk(clk), .rst(rst),
    .wake_request_pin(wake_request_pin), .sequence_enable_pin(sequence_enable_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode_q(mode_q), .bus_active_q(bus_active_q), .clko_q(clko_q),
    .irq_q(irq_q), .active_op_q(op), .active_strm_q(strm));
  always #25 clk = ~clk;
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hang here means a mode never arrived
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      $display("BAD timeout exp 0 got 1");
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wm(input logic [2:0] m, input int lim);
    for (int j = 0; j < lim && mode_q !== m; j++)
      @(posedge clk) #1;
    chk("mode", {13'h0, m}, {13'h0, mode_q});
  endtask
  // counts edges spent in mode m and clock output rises seen meanwhile
  task automatic cntm(input logic [2:0] m, input int lim, output int cc, output int rr);
    logic p;
    cc = 0;
    rr = 0;
    p = clko_q;
    while (mode_q === m && cc < lim) begin
      @(posedge clk) #1;
      if (clko_q === 1'b1 && p === 1'b0) rr++;
      p = clko_q;
      cc++;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 chk("reset mode", 16'h0000, {13'h0, mode_q});
    @(posedge clk) rst <= 1'b0;
    wm(3'h1, 26);
    $display("test reset done");
    wr(8'h09, 16'h0004);
    for (k = 0; k < 5; k++) begin
      wr(8'h06, row_ctl[k]);
      repeat (6) @(posedge clk);
      #1 chk("held idle", 16'h0001, {13'h0, mode_q});
      @(posedge clk) seq_go <= 1'b1;
      wm(3'h6, 20);
      chk("op code", {13'h0, row_exp[k]}, {13'h0, strm, op});
      cntm(3'h6, 4000, c, r);
      chk("op length", 16'h0010, c[15:0]);
      @(posedge clk) seq_go <= 1'b0;
      repeat (8) @(posedge clk);
      wm(3'h1, 30);
      rd(8'h06, d);
      chk("seq kept", row_ctl[k], d);
    end
    $display("test operations done");
    wr(8'h07, 16'h0002);
    wm(3'h2, 4);
    cntm(3'h2, 4000, c, r);
    chk("pre clocks", 16'h0001, {15'h0, r >= 127 && r <= 129});
    chk("hib bus", 16'h0000, {15'h0, bus_active_q});
    rd(8'h09, d);
    chk("hib read", 16'h0000, d);
    @(posedge clk) wake_go <= 1'b1;
    wm(3'h1, 40);
    @(posedge clk) wake_go <= 1'b0;
    rd(8'h09, d);
    chk("clko kept", 16'h0004, d);
    cntm(3'h1, 8, c, r);
    chk("clko rate", 16'h0004, r[15:0]);
    $display("test hibernate done");
    for (k = 0; k < 2; k++) begin
      wr(8'h05, k ? 16'h0010 : 16'h0000);
      rd(8'h31, e);
      rd(8'h32, d);
      wr(8'h1d, e);
      wr(8'h1e, d + 16'h0300);
      wr(8'h07, 16'h0001);
      wm(3'h4, 400);
      wm(3'h1, 20000);
      // irq follows the status bit by one edge
      @(posedge clk) #1;
      chk("wake irq", k[15:0], {15'h0, irq_q});
      rd(8'h24, d);
      chk("wake stat", 16'h0200, d & 16'h0200);
      repeat (2) @(posedge clk);
      #1 chk("irq clear", 16'h0000, {15'h0, irq_q});
    end
    $display("test timer wake done");
    wr(8'h09, 16'h0024);
    wr(8'h05, 16'h0100);
    wr(8'h07, 16'h0201);
    wm(3'h4, 4400);
    cntm(3'h4, 64, c, r);
    chk("doze clko", 16'h0002, r[15:0]);
    cntm(3'h4, 200, c, r);
    chk("deep stays", 16'h00c8, c[15:0]);
    @(posedge clk) wake_go <= 1'b1;
    wm(3'h1, 40);
    @(posedge clk) wake_go <= 1'b0;
    $display("test deep doze done");
    wr(8'h07, 16'h0002);
    wm(3'h3, 4400);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) #1;
    chk("hib reset", 16'h0000, {13'h0, mode_q});
    @(posedge clk) rst <= 1'b0;
    wm(3'h1, 26);
    $display("test hibernate reset done");
    // slowest rates: stopped in doze, held after exit until re-enabled
    wr(8'h09, 16'h0034);
    rd(8'h31, e);
    rd(8'h32, d);
    wr(8'h1d, e);
    wr(8'h1e, d + 16'h4400);
    wr(8'h07, 16'h0001);
    wm(3'h4, 17000);
    cntm(3'h4, 300, c, r);
    chk("doze clko off", 16'h0000, r[15:0]);
    @(posedge clk) wake_go <= 1'b1;
    wm(3'h1, 40);
    @(posedge clk) wake_go <= 1'b0;
    cntm(3'h1, 300, c, r);
    chk("slow clko held", 16'h0000, r[15:0]);
    wr(8'h09, 16'h0030);
    wr(8'h09, 16'h0034);
    cntm(3'h1, 300, c, r);
    chk("slow clko back", 16'h0001, {15'h0, r != 0});
    // armed compare still lands after the wake-pin exit
    repeat (400) @(posedge clk);
    rd(8'h24, d);
    chk("late stat", 16'h0200, d & 16'h0200);
    $display("test slow clock doze done");
    tally_and_finish();
  end
endmodule // test_transceiver_power_mode_control
`default_nettype wire
